// ==== common/bsdx_alu_if.sv ====
// carries operands and results between the executer and its alu
// assumes one clock domain; purely combinational path
`timescale 1ns/1ps
`default_nettype none
interface bsdx_alu_if;
    logic [7:0] acc;
    logic [7:0] mem;
    logic carry;
    logic [7:0] diff;
    logic [7:0] dec;
    logic borrow_n;
    logic half_borrow_n;
    logic range_fault;
    modport exec (output acc, mem, carry,
                  input diff, dec, borrow_n, half_borrow_n, range_fault);
    modport alu (input acc, mem, carry,
                 output diff, dec, borrow_n, half_borrow_n, range_fault);
endinterface
`default_nettype wire

// ==== common/bsdx_consts.svh ====
// constants for the borrow-subtract / decrement-skip execution block
// assumes 8-bit accumulator and data memory bytes
`ifndef BSDX_CONSTS_SVH
`define BSDX_CONSTS_SVH
`define BSDX_FILL_VALUE 8'hFF
`define BSDX_ONE 8'h01
`define BSDX_ZERO 8'h00
`define BSDX_SKIP_CYCLES 2'h2
`define BSDX_FLAG_OV 3
`define BSDX_FLAG_Z 2
`define BSDX_FLAG_AC 1
`define BSDX_FLAG_C 0
`define BSDX_FLAGS_RESET 4'h0
`endif

// ==== common/bsdx_pkg.sv ====
// types for the borrow-subtract / decrement-skip execution block
// assumes the opcode decode happens upstream
package bsdx_pkg;
    typedef enum logic [2:0] {
        BSDX_OP_NONE = 3'h0,
        BSDX_OP_SUB_BORROW_TO_MEM = 3'h1,
        BSDX_OP_DEC_MEM_SKIP_IF_NULL = 3'h2,
        BSDX_OP_DEC_TO_ACC_SKIP_IF_NULL = 3'h3,
        BSDX_OP_FILL_MEM = 3'h4
    } bsdx_op_e;
    typedef enum logic [1:0] {
        BSDX_ST_RUN = 2'b01,
        BSDX_ST_DUMMY = 2'b10
    } bsdx_state_e;
endpackage

// ==== hw/bsdx_alu.sv ====
// subtract-with-borrow and decrement arithmetic
// assumes operands are stable during the cycle
`timescale 1ns/1ps
`default_nettype none
`include "bsdx_consts.svh"
module bsdx_alu (
    bsdx_alu_if.alu io
);
    wire [8:0] full_diff;
    wire [4:0] low_diff;
    wire borrow_in;
    // an inverted carry is the borrow into bit 0
    assign borrow_in = ~io.carry;
    assign full_diff = {1'b0, io.acc} - {1'b0, io.mem} - {8'h00, borrow_in};
    assign low_diff = {1'b0, io.acc[3:0]} - {1'b0, io.mem[3:0]}
                      - {4'h0, borrow_in};
    assign io.diff = full_diff[7:0];
    assign io.borrow_n = ~full_diff[8];
    assign io.half_borrow_n = ~low_diff[4];
    assign io.range_fault = (io.acc[7] ^ io.mem[7]) & (io.acc[7] ^ io.diff[7]);
    assign io.dec = io.mem - `BSDX_ONE;
endmodule // bsdx_alu
`default_nettype wire

// ==== hw/bsdx_exec.sv ====
// execution stage for borrow-subtract, decrement-skip and fill
// assumes decoded op with memory byte read and valid in same cycle
// Notes on behaviour
// - sub_borrow_to_mem stores acc minus memory minus inverted carry.
// - after it, carry is 0 when the result went negative, else 1.
// - it updates signed_range_fault, zero, half_borrow_bit, carry only.
// - dec_mem_skip_if_null stores memory minus one, skips on zero.
// - a skip adds a dummy cycle so the instruction takes two cycles.
// - dec_mem_skip_if_null leaves every status bit as it was.
// - dec_to_acc_skip_if_null loads acc with memory minus one, skips on 0.
// - dec_to_acc_skip_if_null leaves every status bit as it was.
// - fill memory writes FFH into the addressed byte.
`timescale 1ns/1ps
`default_nettype none
`include "bsdx_consts.svh"
module bsdx_exec
    import bsdx_pkg::*;
(
    // clock and reset
    input wire logic clock_in,
    input wire logic rstn_in,
    // decoded instruction and operands
    input wire logic op_valid_in,
    input wire logic [2:0] op_in,
    input wire logic [7:0] mem_rdata_in,
    // results
    output logic mem_we_out,
    output logic [7:0] mem_wdata_out,
    output logic [7:0] acc_out,
    output logic [3:0] flags_out,
    output logic skip_out,
    output logic busy_out
);
    logic rst_meta_r;
    logic rstn_r;
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rst_meta_r <= 1'b0;
            rstn_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rstn_r <= rst_meta_r;
        end
    end

    bsdx_alu_if alu_bus();
    bsdx_alu u_alu (
        .io(alu_bus)
    );

    bsdx_state_e state_r;
    bsdx_state_e state_nxt;
    logic [7:0] acc_r;
    logic [3:0] flags_r;
    logic mem_we_r;
    logic [7:0] mem_wdata_r;
    logic skip_r;
    logic busy_r;

    wire take;
    wire is_sub;
    wire is_dsk;
    wire is_dacc;
    wire is_fill;
    wire dec_null;
    wire want_skip;
    wire [3:0] sub_flags;

    // ops arriving during the dummy cycle are refused; the fetch stage stalls
    assign take = op_valid_in && (state_r == BSDX_ST_RUN);
    assign is_sub = take && (op_in == BSDX_OP_SUB_BORROW_TO_MEM);
    assign is_dsk = take && (op_in == BSDX_OP_DEC_MEM_SKIP_IF_NULL);
    assign is_dacc = take && (op_in == BSDX_OP_DEC_TO_ACC_SKIP_IF_NULL);
    assign is_fill = take && (op_in == BSDX_OP_FILL_MEM);
    assign alu_bus.acc = acc_r;
    assign alu_bus.mem = mem_rdata_in;
    assign alu_bus.carry = flags_r[`BSDX_FLAG_C];
    assign dec_null = (alu_bus.dec == `BSDX_ZERO);
    assign want_skip = (is_dsk || is_dacc) && dec_null;
    assign sub_flags = {alu_bus.range_fault,
                        alu_bus.diff == `BSDX_ZERO,
                        alu_bus.half_borrow_n,
                        alu_bus.borrow_n};

    always_comb begin
        state_nxt = BSDX_ST_RUN;
        unique case (state_r)
            BSDX_ST_RUN: begin
                if (want_skip) begin
                    state_nxt = BSDX_ST_DUMMY;
                end
            end
            BSDX_ST_DUMMY: begin
                state_nxt = BSDX_ST_RUN;
            end
            default: begin
                state_nxt = BSDX_ST_RUN;
            end
        endcase
    end

    always_ff @(posedge clock_in or negedge rstn_r) begin
        if (!rstn_r) begin
            state_r <= BSDX_ST_RUN;
            acc_r <= `BSDX_ZERO;
            flags_r <= `BSDX_FLAGS_RESET;
            mem_we_r <= 1'b0;
            mem_wdata_r <= `BSDX_ZERO;
            skip_r <= 1'b0;
            busy_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            mem_we_r <= is_sub || is_dsk || is_fill;
            mem_wdata_r <= is_fill ? `BSDX_FILL_VALUE :
                           is_sub ? alu_bus.diff : alu_bus.dec;
            if (is_dacc) begin
                acc_r <= alu_bus.dec;
            end
            // only the subtract touches flags; decrements leave them alone
            if (is_sub) begin
                flags_r <= sub_flags;
            end
            skip_r <= want_skip;
            busy_r <= (state_nxt == BSDX_ST_DUMMY);
        end
    end

    assign mem_we_out = mem_we_r;
    assign mem_wdata_out = mem_wdata_r;
    assign acc_out = acc_r;
    assign flags_out = flags_r;
    assign skip_out = skip_r;
    // a flop copy of the dummy state keeps the output free of decode glitches
    assign busy_out = busy_r;

    sequence s_skip_dec;
        want_skip;
    endsequence
    sequence s_dummy_then_run;
        busy_out ##1 !busy_out;
    endsequence

    AST_SUB_RESULT: assert property (@(posedge clock_in) disable iff (!rstn_r)
        is_sub |=> mem_we_out && mem_wdata_out ==
            $past(acc_r) - $past(mem_rdata_in) - {7'h00, ~$past(flags_r[0])})
        else $error("subtract result wrong");
    AST_SUB_CARRY: assert property (@(posedge clock_in) disable iff (!rstn_r)
        is_sub |=> flags_out[0] == ({1'b0, $past(acc_r)} >=
            {1'b0, $past(mem_rdata_in)} + {8'h00, ~$past(flags_r[0])}))
        else $error("carry after subtract wrong");
    AST_SUB_ZERO: assert property (@(posedge clock_in) disable iff (!rstn_r)
        is_sub |=> flags_out[2] == (mem_wdata_out == 8'h00))
        else $error("zero flag mismatch");
    AST_DEC_MEM: assert property (@(posedge clock_in) disable iff (!rstn_r)
        is_dsk |=> mem_we_out && mem_wdata_out == $past(mem_rdata_in) - 8'h01
            && skip_out == (mem_wdata_out == 8'h00))
        else $error("decrement to memory wrong");
    AST_SKIP_TWO: assert property (@(posedge clock_in) disable iff (!rstn_r)
        s_skip_dec |=> s_dummy_then_run)
        else $error("skip does not take two cycles");
    AST_DEC_FLAGS: assert property (@(posedge clock_in) disable iff (!rstn_r)
        (is_dsk || is_dacc) |=> $stable(flags_out))
        else $error("decrement changed flags");
    AST_DACC: assert property (@(posedge clock_in) disable iff (!rstn_r)
        is_dacc |=> acc_out == $past(mem_rdata_in) - 8'h01 && !mem_we_out
            && $stable(flags_out))
        else $error("decrement to acc wrong");
    AST_DACC_FLAGS: assert property (@(posedge clock_in) disable iff (!rstn_r)
        is_dacc |=> flags_out == $past(flags_r))
        else $error("decrement to acc changed flags");
    AST_FILL: assert property (@(posedge clock_in) disable iff (!rstn_r)
        is_fill |=> mem_we_out && mem_wdata_out == 8'hFF)
        else $error("fill value wrong");
    AST_NO_SKIP_ONE: assert property (@(posedge clock_in) disable iff (!rstn_r)
        ((is_dsk || is_dacc) && !dec_null) |=> !busy_out && !skip_out)
        else $error("non-skipping decrement stalled");
endmodule // bsdx_exec
`default_nettype wire

// ==== tb/bsdx_exec_tb.sv ====
// self-checking bench for the borrow-subtract / decrement-skip block
// assumes the bench plays fetch and memory read; no memory model
`timescale 1ns/1ps
`default_nettype none
module bsdx_exec_tb;
    import bsdx_pkg::*;
    typedef struct packed {
        logic [2:0] op;
        logic [7:0] mem;
        logic we;
        logic [7:0] wdata;
        logic [7:0] acc;
        logic [3:0] flags;
        logic skip;
    } bsdx_row_s;
    logic clock_in = 1'b0;
    logic rstn_in = 1'b0;
    logic op_valid_in = 1'b0;
    logic [2:0] op_in = 3'h0;
    logic [7:0] mem_rdata_in = 8'h00;
    logic mem_we_out;
    logic [7:0] mem_wdata_out;
    logic [7:0] acc_out;
    logic [3:0] flags_out;
    logic skip_out;
    logic busy_out;
    int miscompares = 0;
    int checked = 0;
    bsdx_row_s rows [12];
    bsdx_row_s r;
    bsdx_exec DUT (.clock_in(clock_in), .rstn_in(rstn_in),
        .op_valid_in(op_valid_in), .op_in(op_in),
        .mem_rdata_in(mem_rdata_in), .mem_we_out(mem_we_out),
        .mem_wdata_out(mem_wdata_out), .acc_out(acc_out),
        .flags_out(flags_out), .skip_out(skip_out), .busy_out(busy_out));
    always #2 clock_in = ~clock_in;
    task chk(input string name, input logic [7:0] seen,
             input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task final_report;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task drive(input logic [2:0] op, input logic [7:0] mem);
        @(posedge clock_in);
        op_valid_in <= 1'b1;
        op_in <= op;
        mem_rdata_in <= mem;
    endtask
    // released read data is inverted so a stale byte cannot pass
    task settle;
        @(posedge clock_in);
        op_valid_in <= 1'b0;
        mem_rdata_in <= ~mem_rdata_in;
        #1;
    endtask
    initial begin
        // hand-worked chain: acc and carry carry over from row to row
        rows = '{{3'h3, 8'h06, 1'b0, 8'h00, 8'h05, 4'h0, 1'b0},
                 {3'h1, 8'h02, 1'b1, 8'h02, 8'h05, 4'h3, 1'b0},
                 {3'h1, 8'h02, 1'b1, 8'h03, 8'h05, 4'h3, 1'b0},
                 {3'h1, 8'h05, 1'b1, 8'h00, 8'h05, 4'h7, 1'b0},
                 {3'h4, 8'h12, 1'b1, 8'hFF, 8'h05, 4'h7, 1'b0},
                 {3'h1, 8'h06, 1'b1, 8'hFF, 8'h05, 4'h0, 1'b0},
                 {3'h3, 8'h80, 1'b0, 8'h00, 8'h7F, 4'h0, 1'b0},
                 {3'h1, 8'hF0, 1'b1, 8'h8E, 8'h7F, 4'hA, 1'b0},
                 {3'h2, 8'h05, 1'b1, 8'h04, 8'h7F, 4'hA, 1'b0},
                 {3'h2, 8'h01, 1'b1, 8'h00, 8'h7F, 4'hA, 1'b1},
                 {3'h3, 8'h01, 1'b0, 8'h00, 8'h00, 4'hA, 1'b1},
                 {3'h0, 8'h33, 1'b0, 8'h00, 8'h00, 4'hA, 1'b0}};
        repeat (10) @(posedge clock_in);
        chk("acc", acc_out, 8'h00);
        chk("flags", {4'h0, flags_out}, 8'h00);
        rstn_in <= 1'b1;
        repeat (2) @(posedge clock_in);
        $display("test reset done");
        foreach (rows[i]) begin
            r = rows[i];
            drive(r.op, r.mem);
            settle();
            chk("we", {7'h00, mem_we_out}, {7'h00, r.we});
            if (r.we) begin
                chk("wdata", mem_wdata_out, r.wdata);
            end
            chk("acc", acc_out, r.acc);
            chk("flags", {4'h0, flags_out},
                {4'h0, r.flags});
            chk("skip", {7'h00, skip_out}, {7'h00, r.skip});
            chk("busy", {7'h00, busy_out}, {7'h00, r.skip});
        end
        $display("test table done");
        drive(3'h2, 8'h01);
        drive(3'h3, 8'h50);
        #1;
        chk("skip", {7'h00, skip_out}, 8'h01);
        settle();
        chk("busy", {7'h00, busy_out}, 8'h00);
        chk("acc", acc_out, 8'h00);
        chk("we", {7'h00, mem_we_out}, 8'h00);
        $display("test skip refusal done");
        drive(3'h3, 8'h10);
        drive(3'h3, 8'h20);
        #1;
        chk("acc", acc_out, 8'h0F);
        settle();
        chk("acc", acc_out, 8'h1F);
        $display("test back to back done");
        // reset lands in the middle of a skip, while busy is up
        drive(3'h2, 8'h01);
        @(posedge clock_in);
        op_valid_in <= 1'b0;
        rstn_in <= 1'b0;
        #1;
        chk("acc", acc_out, 8'h00);
        chk("flags", {4'h0, flags_out}, 8'h00);
        chk("busy", {7'h00, busy_out}, 8'h00);
        chk("skip", {7'h00, skip_out}, 8'h00);
        chk("we", {7'h00, mem_we_out}, 8'h00);
        @(posedge clock_in);
        rstn_in <= 1'b1;
        repeat (2) @(posedge clock_in);
        drive(3'h1, 8'h00);
        settle();
        chk("wdata", mem_wdata_out, 8'hFF);
        chk("flags", {4'h0, flags_out}, 8'h00);
        // op code still held with valid low must not write again
        @(posedge clock_in);
        #1;
        chk("we", {7'h00, mem_we_out}, 8'h00);
        $display("test mid reset done");
        final_report();
    end
    initial begin
        #20000;
        miscompares++;
        final_report();
    end
endmodule // bsdx_exec_tb
`default_nettype wire
